// ### rtl/lcd_cmd_pkg.sv
// Constants, command codes, register map and types of the display command decoder
package lcd_cmd_pkg;

  // ---------------------------------------------------------------
  // Display memory
  // ---------------------------------------------------------------
  localparam int MEM_AW = 10;

  // ---------------------------------------------------------------
  // Command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_CURSOR = 8'h21;
  localparam logic [7:0] CMD_OFFSET = 8'h22;
  localparam logic [7:0] CMD_PTR = 8'h24;
  localparam logic [7:0] CMD_TEXT_HOME = 8'h40;
  localparam logic [7:0] CMD_TEXT_AREA = 8'h41;
  localparam logic [7:0] CMD_GFX_HOME = 8'h42;
  localparam logic [7:0] CMD_GFX_AREA = 8'h43;
  localparam logic [7:0] CMD_BLINK = 8'h50;
  localparam logic [7:0] CMD_AUTO_MOVE = 8'h60;
  localparam logic [7:0] CMD_FONT = 8'h70;
  localparam logic [7:0] CMD_AUTO_WR = 8'hb0;
  localparam logic [7:0] CMD_AUTO_RD = 8'hb1;
  localparam logic [7:0] CMD_AUTO_END = 8'hb2;
  localparam logic [7:0] CMD_REVERSE = 8'hd0;
  localparam logic [7:0] CMD_PEEK = 8'he0;
  localparam logic [7:0] CMD_COPY = 8'he8;
  localparam logic [3:0] GRP_MODE = 4'h8;
  localparam logic [3:0] GRP_DISP = 4'h9;
  localparam logic [3:0] GRP_BITOP = 4'hf;
  localparam logic [4:0] GRP_CPAT = 5'h14;
  localparam logic [4:0] GRP_RW = 5'h18;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int RW_READ_BIT = 0;
  localparam int RW_DEC_BIT = 1;
  localparam int RW_HOLD_BIT = 2;
  localparam int MODE_FONT_BIT = 3;
  localparam int BITOP_SET_BIT = 3;
  localparam int FONT_ALT_BIT = 1;
  localparam int CD_BIT = 8;
  localparam int RDATA_VALID_BIT = 8;

  // ---------------------------------------------------------------
  // APB register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_PORT = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_RDATA = 8'h08;
  localparam logic [7:0] ADDR_CURSOR = 8'h0c;
  localparam logic [7:0] ADDR_POINTER = 8'h10;
  localparam logic [7:0] ADDR_TEXT = 8'h14;
  localparam logic [7:0] ADDR_GFX = 8'h18;
  localparam logic [7:0] ADDR_MODE = 8'h1c;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [2:0] BLINK_RST = 3'h2;
  localparam logic [1:0] FONT_RST = 2'h0;
  localparam logic [3:0] CURSOR_LINES_RST = 4'h1;

  // Blink period in ms at a 60 Hz frame, indexed by the 3-bit code
  localparam logic [10:0] BLINK_MS [8] = '{11'h042, 11'h0fa, 11'h1f4, 11'h2ee,
                                           11'h3e8, 11'h4e2, 11'h5dc, 11'h7d0};

  typedef enum logic [1:0] {ST_IDLE, ST_RD, ST_RMW, ST_COPY} seq_t;

endpackage

// ### rtl/mem_if.sv
// Port bundle between the command sequencer and the display memory
`timescale 1ns/10ps
interface mem_if;
  import lcd_cmd_pkg::*;
  logic we;
  logic re;
  logic [MEM_AW-1:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctrl (output we, output re, output addr, output wdata, input rdata);
  modport mem (input we, input re, input addr, input wdata, output rdata);
endinterface

// ### rtl/disp_mem.sv
// Single-port display memory with registered read data
`timescale 1ns/10ps
module disp_mem
  import lcd_cmd_pkg::*;
(
  // Clock
  input wire logic pclk,
  // Access port
  mem_if.mem m
);
  logic [7:0] ram [2**MEM_AW];

  always_ff @(posedge pclk) begin
    if (m.we) begin
      ram[m.addr] <= m.wdata;
    end
    if (m.re) begin
      m.rdata <= ram[m.addr];
    end
  end
endmodule

// ### rtl/byte_buf.sv
// Two-entry byte buffer with valid/ready on both sides
`timescale 1ns/10ps
module byte_buf (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [7:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [7:0] out_data
);
  logic [7:0] slot_q [2];
  logic wp_q;
  logic rp_q;
  logic [1:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = slot_q[rp_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'h0;
      slot_q[0] <= 8'h00;
      slot_q[1] <= 8'h00;
    end else begin
      if (push) begin
        slot_q[wp_q] <= in_data;
        wp_q <= ~wp_q;
      end
      if (pop) begin
        rp_q <= ~rp_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// ### rtl/graphic_lcd_command_decoder.sv
// Command decoder of a text/graphics display controller behind an APB slave
//
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/10ps

//
// Contract
// RULE_01 - 21h loads cursor X/Y, 22h the font offset, 24h the pointer low then high
// RULE_02 - 40h..43h load text/graphic home addresses and area column counts
// RULE_03 - Mode set: bit 3 picks font memory, bits 2:0 the combine mode
// RULE_04 - Display mode: all zero turns off, else graphic/text/cursor/blink enables
// RULE_05 - Cursor pattern sets cursor height to code plus one lines
// RULE_06 - Single writes store the last data byte, then step, back or hold pointer
// RULE_07 - Single reads fetch the byte at the pointer, then step, back or hold
// RULE_08 - B0h/B1h enter automatic write/read streaming, B2h leaves it
// RULE_09 - D0h takes first parameter bit 0 as whole-screen reverse
// RULE_10 - 50h sets blink period from bits 2:0, default code 010
// RULE_11 - 60h enables cursor auto-move from bit 0, disabled by default
// RULE_12 - 70h selects alternative fonts for 10/11, ignores 00/01, default 00
// RULE_13 - Those four commands take two parameters and ignore the second
// RULE_14 - 1111sbbb clears or sets one bit by read-modify-write at the pointer
// RULE_15 - E0h returns the displayed byte, E8h copies it into graphic memory
// RULE_16 - Host checks both ready flags before writing any byte; the host model polls only status bit 3 before automatic data bytes
// RULE_17 - Parameters precede the command; only the last one or two count
// RULE_18 - Select bit high marks a command, low a data or parameter byte
module graphic_lcd_command_decoder
  import lcd_cmd_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Display control
  output logic [2:0] combine_mode,
  output logic ext_font,
  output logic [3:0] disp_mode,
  output logic [3:0] cursor_lines,
  output logic screen_reverse,
  output logic [10:0] blink_ms,
  output logic cursor_auto_move,
  output logic [1:0] font_sel
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  seq_t state_q, state_d;
  logic [7:0] first_q, second_q;
  logic [15:0] ptr_q, ptr_d, rw_ptr;
  logic [7:0] cursor_x_q, cursor_y_q, cg_offset_q;
  logic [15:0] text_home_q, gfx_home_q, copy_dst_q;
  logic [7:0] text_area_q, gfx_area_q;
  logic [2:0] blink_code_q, bitsel_q;
  logic auto_wr_q, auto_rd_q, peek_q, bitset_q;
  logic [31:0] prdata_q;
  logic [31:0] rd_word;
  logic sel_port, sel_status, sel_rdata, sel_cursor, sel_pointer, sel_text, sel_gfx, sel_mode, mapped;
  logic apb_setup, apb_access, idle, port_ok, host_wr, host_cmd, host_data, auto_data, param_data;
  logic is_cmd, is_mode, is_disp, is_cpat, is_rw, is_bitop, single_wr, single_rd, do_peek, do_copy, do_bitop;
  logic prefetch;
  logic [7:0] wbyte, shown_byte, rmw_byte, bit_mask, status;
  logic buf_in_ready, buf_out_valid, buf_out_ready;
  logic [7:0] buf_out_data, buf_in_data;
  mem_if mif ();

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  assign apb_setup = psel & ~penable;
  assign apb_access = psel & penable;
  assign sel_port = (paddr == ADDR_PORT);
  assign sel_status = (paddr == ADDR_STATUS);
  assign sel_rdata = (paddr == ADDR_RDATA);
  assign sel_cursor = (paddr == ADDR_CURSOR);
  assign sel_pointer = (paddr == ADDR_POINTER);
  assign sel_text = (paddr == ADDR_TEXT);
  assign sel_gfx = (paddr == ADDR_GFX);
  assign sel_mode = (paddr == ADDR_MODE);
  assign mapped = sel_port | sel_status | sel_rdata | sel_cursor | sel_pointer | sel_text | sel_gfx | sel_mode;
  assign idle = (state_q == ST_IDLE);
  // Bytes arriving while busy are refused, since the host owes a status check
  assign port_ok = idle & buf_in_ready; // RULE_16
  assign pready = 1'b1;
  assign pslverr = apb_access & (~mapped | (pwrite & sel_port & ~port_ok));
  assign prdata = prdata_q;
  assign host_wr = apb_access & pwrite & sel_port & port_ok;
  assign wbyte = pwdata[7:0];
  assign is_cmd = pwdata[CD_BIT];
  assign host_cmd = host_wr & is_cmd; // RULE_18
  assign host_data = host_wr & ~is_cmd; // RULE_18
  assign auto_data = host_data & auto_wr_q; // RULE_08
  assign param_data = host_data & ~auto_wr_q;

  // ---------------------------------------------------------------
  // Read-back
  // ---------------------------------------------------------------
  assign status = {(disp_mode != 4'h0), 1'b0, 1'b1, 1'b0, auto_wr_q & idle, auto_rd_q & buf_out_valid,
                   port_ok, port_ok};
  assign rd_word = sel_status ? {24'h000000, status} :
                   sel_rdata ? {23'h000000, buf_out_valid, buf_out_data} :
                   sel_cursor ? {16'h0000, cursor_y_q, cursor_x_q} :
                   sel_pointer ? {8'h00, cg_offset_q, ptr_q} :
                   sel_text ? {8'h00, text_area_q, text_home_q} :
                   sel_gfx ? {8'h00, gfx_area_q, gfx_home_q} :
                   sel_mode ? {12'h000, auto_rd_q, auto_wr_q, font_sel, cursor_auto_move, blink_code_q,
                               screen_reverse, 3'(cursor_lines - 4'h1), disp_mode, ext_font, combine_mode} :
                   32'h00000000;
  // Popping only a byte that was shown keeps a late push from being lost
  assign buf_out_ready = apb_access & ~pwrite & sel_rdata & prdata_q[RDATA_VALID_BIT];

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  assign is_mode = (wbyte[7:4] == GRP_MODE);
  assign is_disp = (wbyte[7:4] == GRP_DISP);
  assign is_cpat = (wbyte[7:3] == GRP_CPAT);
  assign is_rw = (wbyte[7:3] == GRP_RW) & ~(wbyte[RW_HOLD_BIT] & wbyte[RW_DEC_BIT]);
  assign is_bitop = (wbyte[7:4] == GRP_BITOP);
  assign single_wr = host_cmd & is_rw & ~wbyte[RW_READ_BIT]; // RULE_06
  assign single_rd = host_cmd & is_rw & wbyte[RW_READ_BIT]; // RULE_07
  assign do_peek = host_cmd & (wbyte == CMD_PEEK); // RULE_15
  assign do_copy = host_cmd & (wbyte == CMD_COPY); // RULE_15
  assign do_bitop = host_cmd & is_bitop; // RULE_14
  // Host traffic has priority over read-ahead; one byte ahead keeps the port free
  assign prefetch = idle & auto_rd_q & ~buf_out_valid & ~host_wr; // RULE_08
  assign rw_ptr = wbyte[RW_HOLD_BIT] ? ptr_q : wbyte[RW_DEC_BIT] ? ptr_q - 16'h0001 : ptr_q + 16'h0001;
  assign ptr_d = (host_cmd & (wbyte == CMD_PTR)) ? {second_q, first_q} : // RULE_01
                 (single_wr | single_rd) ? rw_ptr : // RULE_06 RULE_07
                 (auto_data | prefetch) ? ptr_q + 16'h0001 : ptr_q; // RULE_08

  // ---------------------------------------------------------------
  // Memory access
  // ---------------------------------------------------------------
  assign shown_byte = mif.rdata ^ {8{screen_reverse}};
  assign bit_mask = 8'h01 << bitsel_q;
  assign rmw_byte = bitset_q ? (mif.rdata | bit_mask) : (mif.rdata & ~bit_mask); // RULE_14
  assign mif.we = single_wr | auto_data | (state_q == ST_RMW) | (state_q == ST_COPY);
  assign mif.re = single_rd | do_peek | do_copy | do_bitop | prefetch;
  assign mif.addr = (state_q == ST_COPY) ? copy_dst_q[MEM_AW-1:0] : ptr_q[MEM_AW-1:0];
  assign mif.wdata = (state_q == ST_RMW) ? rmw_byte :
                     (state_q == ST_COPY) ? shown_byte : // RULE_15
                     auto_data ? wbyte : second_q; // RULE_06
  assign buf_in_data = peek_q ? shown_byte : mif.rdata;

  disp_mem u_mem (
    .pclk (pclk),
    .m (mif.mem)
  );

  byte_buf u_buf (
    .pclk (pclk),
    .presetn (presetn),
    .in_valid (state_q == ST_RD),
    .in_ready (buf_in_ready),
    .in_data (buf_in_data),
    .out_valid (buf_out_valid),
    .out_ready (buf_out_ready),
    .out_data (buf_out_data)
  );

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_d = ST_IDLE;
    case (state_q)
      ST_IDLE: begin
        if (single_rd | do_peek | prefetch) begin
          state_d = ST_RD;
        end else if (do_bitop) begin
          state_d = ST_RMW;
        end else if (do_copy) begin
          state_d = ST_COPY;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      ptr_q <= 16'h0000;
      prdata_q <= 32'h00000000;
      peek_q <= 1'b0;
      bitset_q <= 1'b0;
      bitsel_q <= 3'h0;
      copy_dst_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      ptr_q <= ptr_d;
      if (apb_setup) begin
        prdata_q <= rd_word;
      end
      if (idle) begin
        peek_q <= do_peek;
        bitset_q <= wbyte[BITOP_SET_BIT];
        bitsel_q <= wbyte[2:0];
        copy_dst_q <= gfx_home_q + (ptr_q - text_home_q);
      end
    end
  end

  // ---------------------------------------------------------------
  // Parameter bytes and setting registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_q <= 8'h00;
      second_q <= 8'h00;
    end else if (param_data) begin
      first_q <= second_q; // RULE_17
      second_q <= wbyte; // RULE_17
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cursor_x_q <= 8'h00;
      cursor_y_q <= 8'h00;
      cg_offset_q <= 8'h00;
      text_home_q <= 16'h0000;
      gfx_home_q <= 16'h0000;
      text_area_q <= 8'h00;
      gfx_area_q <= 8'h00;
    end else if (host_cmd) begin
      if (wbyte == CMD_CURSOR) begin
        cursor_x_q <= first_q; // RULE_01
        cursor_y_q <= second_q; // RULE_01
      end
      if (wbyte == CMD_OFFSET) begin
        cg_offset_q <= first_q; // RULE_01
      end
      if (wbyte == CMD_TEXT_HOME) begin
        text_home_q <= {second_q, first_q}; // RULE_02
      end
      if (wbyte == CMD_GFX_HOME) begin
        gfx_home_q <= {second_q, first_q}; // RULE_02
      end
      if (wbyte == CMD_TEXT_AREA) begin
        text_area_q <= first_q; // RULE_02
      end
      if (wbyte == CMD_GFX_AREA) begin
        gfx_area_q <= first_q; // RULE_02
      end
    end
  end

  // ---------------------------------------------------------------
  // Mode registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      combine_mode <= 3'h0;
      ext_font <= 1'b0;
      disp_mode <= 4'h0;
      cursor_lines <= CURSOR_LINES_RST;
      screen_reverse <= 1'b0;
      blink_code_q <= BLINK_RST;
      blink_ms <= BLINK_MS[BLINK_RST];
      cursor_auto_move <= 1'b0;
      font_sel <= FONT_RST;
      auto_wr_q <= 1'b0;
      auto_rd_q <= 1'b0;
    end else if (host_cmd) begin
      if (is_mode) begin
        combine_mode <= wbyte[2:0]; // RULE_03
        ext_font <= wbyte[MODE_FONT_BIT]; // RULE_03
      end
      if (is_disp) begin
        disp_mode <= wbyte[3:0]; // RULE_04
      end
      if (is_cpat) begin
        cursor_lines <= {1'b0, wbyte[2:0]} + 4'h1; // RULE_05
      end
      // First of the two parameter bytes counts, the second is ignored
      if (wbyte == CMD_REVERSE) begin
        screen_reverse <= first_q[0]; // RULE_09 RULE_13
      end
      if (wbyte == CMD_BLINK) begin
        blink_code_q <= first_q[2:0]; // RULE_10 RULE_13
        blink_ms <= BLINK_MS[first_q[2:0]]; // RULE_10
      end
      if (wbyte == CMD_AUTO_MOVE) begin
        cursor_auto_move <= first_q[0]; // RULE_11 RULE_13
      end
      if ((wbyte == CMD_FONT) & first_q[FONT_ALT_BIT]) begin
        font_sel <= first_q[1:0]; // RULE_12 RULE_13
      end
      if ((wbyte == CMD_AUTO_WR) | (wbyte == CMD_AUTO_RD) | (wbyte == CMD_AUTO_END)) begin
        auto_wr_q <= (wbyte == CMD_AUTO_WR); // RULE_08
        auto_rd_q <= (wbyte == CMD_AUTO_RD); // RULE_08
      end
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_cursor_load;
    host_cmd && wbyte == CMD_CURSOR |=> cursor_x_q == $past(first_q) && cursor_y_q == $past(second_q);
  endproperty
  a_cursor_load: assert property (p_cursor_load) else $error("cursor not loaded"); // RULE_01

  property p_home_load;
    host_cmd && wbyte == CMD_GFX_HOME |=> gfx_home_q == {$past(second_q), $past(first_q)};
  endproperty
  a_home_load: assert property (p_home_load) else $error("graphic home wrong"); // RULE_02

  property p_mode_set;
    host_cmd && is_mode |=> combine_mode == $past(wbyte[2:0]) && ext_font == $past(wbyte[3]);
  endproperty
  a_mode_set: assert property (p_mode_set) else $error("mode set wrong"); // RULE_03

  property p_disp_off;
    host_cmd && wbyte == {GRP_DISP, 4'h0} |=> disp_mode == 4'h0 ##1 status[7] == 1'b0;
  endproperty
  a_disp_off: assert property (p_disp_off) else $error("display not off"); // RULE_04

  property p_cursor_lines;
    host_cmd && is_cpat |=> cursor_lines == {1'b0, $past(wbyte[2:0])} + 4'h1;
  endproperty
  a_cursor_lines: assert property (p_cursor_lines) else $error("cursor height wrong"); // RULE_05

  property p_write_step;
    single_wr |-> mif.we ##1 ptr_q == $past(rw_ptr);
  endproperty
  a_write_step: assert property (p_write_step) else $error("single write step wrong"); // RULE_06

  property p_read_push;
    single_rd |=> state_q == ST_RD ##1 buf_out_valid;
  endproperty
  a_read_push: assert property (p_read_push) else $error("read byte not buffered"); // RULE_07

  property p_auto_end;
    host_cmd && wbyte == CMD_AUTO_END |=> !auto_wr_q && !auto_rd_q [*2];
  endproperty
  a_auto_end: assert property (p_auto_end) else $error("auto mode not left"); // RULE_08

  property p_reverse;
    host_cmd && wbyte == CMD_REVERSE |=> screen_reverse == $past(first_q[0]);
  endproperty
  a_reverse: assert property (p_reverse) else $error("reverse wrong"); // RULE_09

  property p_font_hold;
    host_cmd && wbyte == CMD_FONT && !first_q[1] |=> $stable(font_sel);
  endproperty
  a_font_hold: assert property (p_font_hold) else $error("font changed on ignored code"); // RULE_12

  property p_bitop;
    do_bitop |=> state_q == ST_RMW && mif.we ##1 idle;
  endproperty
  a_bitop: assert property (p_bitop) else $error("bit operation not written back"); // RULE_14

  property p_param_shift;
    param_data |=> second_q == $past(wbyte) && first_q == $past(second_q);
  endproperty
  a_param_shift: assert property (p_param_shift) else $error("parameter bytes wrong"); // RULE_17

  c_auto_read: cover property (host_cmd && wbyte == CMD_AUTO_RD ##[1:20] buf_out_ready);
  c_buf_full: cover property (!buf_in_ready);
  c_bitop: cover property (do_bitop ##2 idle);
  c_copy: cover property (do_copy ##1 state_q == ST_COPY);

endmodule

// ### tb/host_model.sv
// Host model: APB master that checks the ready flags before each port write
`timescale 1ns/10ps
module host_model
  import lcd_cmd_pkg::*;
(
  // Clock
  input wire logic pclk,
  // APB master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // Bench hooks
  output logic mark,
  output logic hung
);
  // ----
  // Bus cycles
  // ----
  initial begin
    {psel, penable, pwrite, paddr, pwdata, mark, hung} = '0;
  end
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic c, output logic [31:0] r);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    mark <= c;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (pready !== 1'b1) hung <= 1'b1;
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    mark <= 1'b0;
  endtask
  // Bounded, so a stuck busy flag ends the run instead of hanging it
  task poll(input logic [3:0] m);
    logic [31:0] s;
    int n;
    n = 0;
    do begin
      xfer(1'b0, ADDR_STATUS, 32'h0, 1'b0, s);
      n++;
    end while ((s[3:0] & m) !== m && n < 200);
    if ((s[3:0] & m) !== m) hung <= 1'b1;
  endtask
  task put(input logic [8:0] b, input logic [3:0] m);
    logic [31:0] s;
    poll(m);
    xfer(1'b1, ADDR_PORT, {23'h0, b}, 1'b0, s);
  endtask
endmodule

// ### tb/tb_graphic_lcd_command_decoder.sv
// Testbench of the display command decoder
`timescale 1ns/10ps
module tb_graphic_lcd_command_decoder import lcd_cmd_pkg::*;;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, mark, hung;
  logic ext_font, screen_reverse, cursor_auto_move;
  logic [7:0] paddr, a, b;
  logic [31:0] pwdata, prdata, seed;
  logic [2:0] combine_mode, n;
  logic [3:0] disp_mode, cursor_lines;
  logic [10:0] blink_ms;
  logic [1:0] font_sel;
  logic [64:0] exp_q[$];
  logic [64:0] e;
  logic [2:0] cm [4] = '{3'h0, 3'h1, 3'h3, 3'h4};
  logic [3:0] dm [4] = '{4'h0, 4'h5, 4'ha, 4'hf};
  logic [1:0] fc [4] = '{2'h2, 2'h1, 2'h3, 2'h0};
  logic [1:0] fe [4] = '{2'h2, 2'h2, 2'h3, 2'h3};
  int bad_count, compares;
  // ----
  // Harness
  // ----
  graphic_lcd_command_decoder dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .combine_mode, .ext_font, .disp_mode, .cursor_lines, .screen_reverse, .blink_ms,
    .cursor_auto_move, .font_sel);
  host_model host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .mark, .hung);
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task cmp(input string s, input logic [31:0] seen, input logic [31:0] x);
    compares++;
    if (seen !== x) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", s, x, seen);
    end
  endtask
  task chk(input logic [7:0] ad, input logic [31:0] x, input logic [31:0] m, input logic w = 1'b0,
    input logic er = 1'b0);
    logic [31:0] r;
    exp_q.push_back({er, m, x & m});
    host.xfer(w, ad, x, 1'b1, r);
  endtask
  task settle();
    repeat (3) @(negedge pclk);
  endtask
  task c0(input logic [7:0] c);
    host.put({1'b1, c}, 4'h3);
  endtask
  task c2(input logic [7:0] d1, input logic [7:0] d2, input logic [7:0] c);
    host.put({1'b0, d1}, 4'h3);
    host.put({1'b0, d2}, 4'h3);
    c0(c);
  endtask
  task summarize();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Oldest note is matched against each marked transfer
  always @(posedge pclk) begin
    if (psel && penable && pready && mark) begin
      e = exp_q.pop_front();
      cmp("prdata", prdata & e[63:32], e[31:0]);
      cmp("pslverr", {31'h0, pslverr}, {31'h0, e[64]});
    end
  end
  initial begin
    repeat (90000) begin
      @(posedge pclk);
      if (hung === 1'b1) break;
    end
    bad_count++;
    summarize();
  end
  // ----
  // Scenarios
  // ----
  initial begin
    seed = 32'hef48;
    presetn = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    chk(ADDR_MODE, 32'h2000, '1);
    cmp("reset", {17'h0, cursor_lines, blink_ms}, {17'h0, 4'h1, 11'h1f4});
    chk(8'h20, 32'h0, '1, 1'b0, 1'b1);
    a = rnd();
    b = rnd();
    host.put({1'b0, rnd()}, 4'h3);
    c2(a, b, CMD_CURSOR);
    chk(ADDR_CURSOR, {16'h0, b, a}, 32'hffff);
    c2(a, 8'h00, CMD_OFFSET);
    c2(8'h20, 8'h01, CMD_PTR);
    chk(ADDR_POINTER, {8'h0, a, 16'h0120}, 32'hffffff);
    for (int i = 0; i < 2; i++) begin
      a = rnd();
      b = rnd();
      c2(a, b, i ? CMD_GFX_HOME : CMD_TEXT_HOME);
      c2(b, 8'h00, i ? CMD_GFX_AREA : CMD_TEXT_AREA);
      chk(i ? ADDR_GFX : ADDR_TEXT, {8'h0, b, b, a}, 32'hffffff);
    end
    for (int i = 0; i < 4; i++) begin
      a = rnd();
      c0({4'h8, i[0], cm[i]});
      c0({4'h9, dm[i]});
      c2({a[7:1], ~i[0]}, rnd(), CMD_REVERSE);
      c2({a[7:1], ~i[0]}, rnd(), CMD_AUTO_MOVE);
      c2({a[7:2], fc[i]}, rnd(), CMD_FONT);
      settle();
      cmp("modes", {20'h0, ext_font, combine_mode, disp_mode, screen_reverse, cursor_auto_move, font_sel},
        {20'h0, i[0], cm[i], dm[i], ~i[0], ~i[0], fe[i]});
    end
    for (int i = 0; i < 8; i++) begin
      a = rnd();
      c0({5'h14, i[2:0]});
      c2({a[7:3], i[2:0]}, rnd(), CMD_BLINK);
      settle();
      cmp("cursor blink", {17'h0, cursor_lines, blink_ms}, {17'h0, 4'(i + 1), BLINK_MS[i]});
    end
    a = rnd();
    b = rnd();
    // Writes at 120h with step, back, hold: 120h=b, 121h=a
    for (int i = 0; i < 3; i++) begin
      host.put({1'b0, i == 2 ? b : a}, 4'h3);
      c0(8'hc0 | 8'(i * 2));
    end
    chk(ADDR_POINTER, 32'h0120, 32'hffff);
    c0(8'hc1);
    c0(8'hc5);
    settle();
    chk(ADDR_STATUS, 32'h0, 32'h3);
    chk(ADDR_PORT, 32'h1c1, 32'h0, 1'b1, 1'b1);
    chk(ADDR_RDATA, {23'h0, 1'b1, b}, 32'h1ff);
    chk(ADDR_RDATA, {23'h0, 1'b1, a}, 32'h1ff);
    chk(ADDR_RDATA, 32'h0, 32'h100);
    chk(ADDR_POINTER, 32'h0121, 32'hffff);
    c0(8'hc3);
    settle();
    chk(ADDR_RDATA, {23'h0, 1'b1, a}, 32'h1ff);
    chk(ADDR_POINTER, 32'h0120, 32'hffff);
    a = rnd();
    n = a[2:0];
    for (int s = 1; s >= 0; s--) begin
      c0({4'hf, s[0], n});
      c0(s ? CMD_PEEK : 8'hc5);
      settle();
      chk(ADDR_RDATA, {23'h0, 1'b1, s ? b | (8'h1 << n) : b & ~(8'h1 << n)}, 32'h1ff);
    end
    // Copy with reverse on lands inverted at graphic home plus pointer minus text home
    c2(8'h00, 8'h00, CMD_TEXT_HOME);
    c2(8'h00, 8'h02, CMD_GFX_HOME);
    c2(8'h01, rnd(), CMD_REVERSE);
    c0(CMD_COPY);
    c2(8'h20, 8'h03, CMD_PTR);
    c0(8'hc5);
    settle();
    chk(ADDR_RDATA, {23'h0, 1'b1, ~(b & ~(8'h1 << n))}, 32'h1ff);
    c2(8'h40, 8'h01, CMD_PTR);
    c0(CMD_AUTO_WR);
    chk(ADDR_MODE, 32'h40000, 32'hc0000);
    host.put({1'b0, a}, 4'h8);
    host.put({1'b0, b}, 4'h8);
    c0(CMD_AUTO_END);
    c2(8'h40, 8'h01, CMD_PTR);
    c0(CMD_AUTO_RD);
    for (int i = 0; i < 2; i++) begin
      host.poll(4'h4);
      chk(ADDR_RDATA, {23'h0, 1'b1, i ? b : a}, 32'h1ff);
    end
    c0(CMD_AUTO_END);
    chk(ADDR_MODE, 32'h0, 32'hc0000);
    summarize();
  end
endmodule
